// ---- hlt_consts.svh ----
// Register offsets, field positions, reset values and codes of the limit timer.
// Assumes a 32-bit APB with byte addresses; included by bare name.
`ifndef HLT_CONSTS_SVH
`define HLT_CONSTS_SVH
`define HLT_AW 8
`define HLT_OFS_CLKSEL 8'h00
`define HLT_OFS_CTRL 8'h04
`define HLT_OFS_LIMIT 8'h08
`define HLT_OFS_RSTSEL 8'h0C
`define HLT_OFS_COUNT 8'h10
`define HLT_OFS_PERIOD 8'h14
`define HLT_OFS_IRQ_STAT 8'h18
`define HLT_OFS_IRQ_MASK 8'h1C
`define HLT_RST_REG 8'h00
`define HLT_RST_PERIOD 8'hFF
`define HLT_CTRL_ON 7
`define HLT_LIM_PRESCALER_SYNC_EN 7
`define HLT_LIM_CLOCK_EDGE_POLARITY 6
`define HLT_LIM_ENABLE_SYNC_TO_TIMER_CLOCK 5
`define HLT_SEL_MASK 8'h0F
`define HLT_IRQ_MASK 8'h03
`define HLT_IRQ_MATCH 0
`define HLT_IRQ_START 1
`define HLT_MODE_MONO_RISE 5'h11
`define HLT_MODE_MONO_FALL 5'h12
`define HLT_MODE_MONO_ANY 5'h13
`define HLT_MODE_LVL_LOW 5'h16
`define HLT_MODE_LVL_HIGH 5'h17
`define HLT_CS_HFOSC 4'h3
`define HLT_CS_LFOSC 4'h4
`define HLT_CS_MFOSC_FAST 4'h5
`define HLT_CS_MFOSC_SLOW 4'h6
`define HLT_ENSYNC_TICKS 2
`endif

// ---- hlt_pkg.sv ----
// Types of the limit timer: state machine and the packed state record.
// Assumes hlt_consts.svh for all numeric values.
package hlt_pkg;
  typedef enum logic [3:0] {
    HLT_ST_IDLE = 4'h1,
    HLT_ST_WAIT = 4'h2,
    HLT_ST_RUN = 4'h4,
    HLT_ST_HALT = 4'h8
  } hlt_state_t;
  typedef struct packed {
    logic [7:0] clksel;
    logic [7:0] ctrl;
    logic [7:0] limit;
    logic [7:0] rstsel;
    logic [7:0] count;
    logic [7:0] period;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [15:0] clk_s1;
    logic [15:0] clk_s2;
    logic [15:0] ers_s1;
    logic [15:0] ers_s2;
    logic clk_prev;
    logic ers_prev;
    logic [6:0] presc;
    logic [3:0] post;
    logic [1:0] ensync;
    hlt_state_t state;
    logic tb_match;
    logic post_match;
    logic pwm_start;
    logic irq;
    logic [2:0] osc_keep;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } hlt_regs_t;
endpackage

// ---- hlt_timer.sv ----
// 8-bit hardware limit timer with prescaler, postscaler and APB registers.
// Assumes pclk is the instruction clock; clock and reset sources arrive
// asynchronously as 16-bit vectors and sleep_in is on the pclk domain.
// Operation
// RULE_01 - Monostable modes start on chosen external edge, stop at period match.
// RULE_02 - Monostable PWM drive starts only on starting edge, never on match.
// RULE_03 - Level one-shot holds count reset at reset level; counts otherwise.
// RULE_04 - Level one-shot match resets count, clears enable; stays reset meanwhile.
// RULE_05 - Level one-shot PWM starts on whichever of edge or enable starts count.
// RULE_06 - With prescaler sync set, timer halts in sleep, registers kept.
// RULE_07 - Without prescaler sync, runs in sleep; selected oscillator kept running.
// RULE_08 - Four-bit field selects timer clock source.
// RULE_09 - Clearing enable stops timer and resets counters and state machines.
// RULE_10 - Three-bit prescale divides input clock by powers of two.
// RULE_11 - Four-bit postscale divides match output by value plus one.
// RULE_12 - Prescaler sync keeps count reads valid on instruction clock.
// RULE_13 - Polarity bit picks falling or rising clock edge; keep fixed while on.
// RULE_14 - Enable sync delays operation two timer input clocks.
// RULE_15 - Default modes run while enabled; stopping keeps the count.
// RULE_16 - Count equal to period clears to zero on next timer clock.
// RULE_17 - Four-bit field selects external reset source.
// RULE_18 - Five-bit mode field sits in bits 4-0 of limit control.
// RULE_19 - Eight-bit count and period compared each prescaled clock.
//
// Chosen here: the address map and the APB interface to the registers.
`include "hlt_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module hlt_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] clk_src_in,
  input wire logic [15:0] ext_reset_src_in,
  input wire logic sleep_in,
  output logic [7:0] count_o,
  output logic tb_match_o,
  output logic post_match_o,
  output logic pwm_start_o,
  output logic [2:0] osc_keep_o,
  output logic irq_o
);

  hlt_pkg::hlt_regs_t s_r;
  hlt_pkg::hlt_regs_t s_nxt;

  // All-ones mask of the prescaler bits that must be set for one output tick.
  function automatic logic [6:0] presc_mask(input logic [2:0] sel);
    logic [7:0] one_hot;
    one_hot = 8'h01 << sel;
    presc_mask = 7'(one_hot - 8'h01);
  endfunction

  function automatic logic is_mono(input logic [4:0] m);
    is_mono = (m == `HLT_MODE_MONO_RISE) || (m == `HLT_MODE_MONO_FALL) ||
              (m == `HLT_MODE_MONO_ANY);
  endfunction

  function automatic logic is_level(input logic [4:0] m);
    is_level = (m == `HLT_MODE_LVL_LOW) || (m == `HLT_MODE_LVL_HIGH);
  endfunction

  function automatic logic [31:0] zext(input logic [7:0] v);
    zext = {24'h000000, v};
  endfunction

  logic wr_en;
  logic rd_en;
  logic on_bit;
  logic prescaler_sync_en;
  logic clock_edge_polarity;
  logic enable_sync_to_timer_clock;
  logic [4:0] mode;
  logic clk_lvl;
  logic clk_edge;
  logic run_ok;
  logic tick;
  logic ptick;
  logic on_eff;
  logic ers_lvl;
  logic ers_rise;
  logic ers_fall;
  logic start_edge;
  logic rst_level;
  logic at_period;
  logic match;
  logic hw_clear_on;
  logic start_evt;
  logic [31:0] rd_val;
  logic [7:0] wbyte;
  logic [1:0] irq_set;
  logic keep_osc;

  always_comb begin
    s_nxt = s_r;
    wr_en = psel & penable & pwrite & s_r.pready;
    rd_en = psel & penable & ~pwrite & ~s_r.pready;
    wbyte = pwdata[7:0];
    on_bit = s_r.ctrl[`HLT_CTRL_ON];
    prescaler_sync_en = s_r.limit[`HLT_LIM_PRESCALER_SYNC_EN];
    clock_edge_polarity = s_r.limit[`HLT_LIM_CLOCK_EDGE_POLARITY];
    enable_sync_to_timer_clock = s_r.limit[`HLT_LIM_ENABLE_SYNC_TO_TIMER_CLOCK];
    mode = s_r.limit[4:0]; // see RULE_18
    hw_clear_on = 1'b0;
    start_evt = 1'b0;
    match = 1'b0;

    // Both source vectors pass two flip-flops before the selectors.
    s_nxt.clk_s1 = clk_src_in;
    s_nxt.clk_s2 = s_r.clk_s1;
    s_nxt.ers_s1 = ext_reset_src_in;
    s_nxt.ers_s2 = s_r.ers_s1;

    // Clock source mux; reserved codes select an input left unconnected.
    clk_lvl = s_r.clk_s2[s_r.clksel[3:0]]; // see RULE_08
    ers_lvl = s_r.ers_s2[s_r.rstsel[3:0]]; // see RULE_17
    s_nxt.clk_prev = clk_lvl;
    s_nxt.ers_prev = ers_lvl;

    // The active input edge is picked by the polarity bit.
    clk_edge = clock_edge_polarity ? (s_r.clk_prev & ~clk_lvl) : (~s_r.clk_prev & clk_lvl); // see RULE_13
    // With prescaler sync set the timer freezes in sleep.
    run_ok = ~(sleep_in & prescaler_sync_en); // see RULE_06 see RULE_07
    tick = clk_edge & run_ok;

    ers_rise = ~s_r.ers_prev & ers_lvl;
    ers_fall = s_r.ers_prev & ~ers_lvl;
    case (mode)
      `HLT_MODE_MONO_RISE: start_edge = ers_rise;
      `HLT_MODE_MONO_FALL: start_edge = ers_fall;
      `HLT_MODE_MONO_ANY: start_edge = ers_rise | ers_fall; // see RULE_01
      default: start_edge = 1'b0;
    endcase
    rst_level = (mode == `HLT_MODE_LVL_LOW) ? ~ers_lvl : ers_lvl;

    // The enable passes two timer input clocks when enable sync is set.
    if (tick) begin
      s_nxt.ensync = {s_r.ensync[0], on_bit}; // see RULE_14
    end
    on_eff = on_bit & (~enable_sync_to_timer_clock | s_r.ensync[`HLT_ENSYNC_TICKS - 1]);

    // Prescaler counts timer input edges; its output is on the pclk domain.
    ptick = 1'b0;
    if (tick & on_eff) begin
      if ((s_r.presc & presc_mask(s_r.ctrl[6:4])) == presc_mask(s_r.ctrl[6:4])) begin
        ptick = 1'b1; // see RULE_10 see RULE_12
        s_nxt.presc = 7'h00;
      end else begin
        s_nxt.presc = 7'(s_r.presc + 7'h01);
      end
    end
    at_period = (s_r.count == s_r.period); // see RULE_19

    case (s_r.state)
      hlt_pkg::HLT_ST_IDLE: begin
        if (on_eff) begin
          s_nxt.state = (is_mono(mode) | is_level(mode)) ? hlt_pkg::HLT_ST_WAIT
                                                         : hlt_pkg::HLT_ST_RUN;
        end
      end
      hlt_pkg::HLT_ST_WAIT: begin
        if (is_mono(mode) && start_edge) begin
          s_nxt.state = hlt_pkg::HLT_ST_RUN;
          start_evt = 1'b1; // see RULE_02
        end else if (is_level(mode) && !rst_level) begin
          s_nxt.state = hlt_pkg::HLT_ST_RUN;
          start_evt = 1'b1; // see RULE_05
        end
      end
      hlt_pkg::HLT_ST_RUN: begin
        // Edges while running are ignored in monostable modes.
        if (ptick) begin
          if (at_period) begin
            s_nxt.count = 8'h00; // see RULE_16
            match = 1'b1;
            if (is_mono(mode)) begin
              s_nxt.state = hlt_pkg::HLT_ST_HALT; // see RULE_01
            end else if (is_level(mode)) begin
              hw_clear_on = 1'b1; // see RULE_04
              s_nxt.state = hlt_pkg::HLT_ST_IDLE;
            end
          end else begin
            s_nxt.count = 8'(s_r.count + 8'h01); // see RULE_15
          end
        end
      end
      hlt_pkg::HLT_ST_HALT: begin
        // A monostable stays stopped until re-armed by the next edge.
        if (start_edge) begin
          s_nxt.state = hlt_pkg::HLT_ST_RUN;
          start_evt = 1'b1; // see RULE_02
        end
      end
      default: s_nxt.state = hlt_pkg::HLT_ST_IDLE;
    endcase

    // Level modes hold the count in reset on the reset level or while off.
    if (is_level(mode) && (rst_level || !on_eff)) begin
      s_nxt.count = 8'h00; // see RULE_03 see RULE_04
      if (on_eff) begin
        s_nxt.state = hlt_pkg::HLT_ST_WAIT;
      end
    end

    // Switching off resets prescaler, postscaler and state; outside the level modes the count stays.
    if (!on_eff) begin
      s_nxt.presc = 7'h00; // see RULE_09 see RULE_15
      s_nxt.post = 4'h0;
      s_nxt.state = hlt_pkg::HLT_ST_IDLE;
      start_evt = 1'b0;
    end

    // Postscaler divides matches by the field value plus one.
    s_nxt.post_match = 1'b0;
    if (match) begin
      if (s_r.post == s_r.ctrl[3:0]) begin
        s_nxt.post = 4'h0; // see RULE_11
        s_nxt.post_match = 1'b1;
      end else begin
        s_nxt.post = 4'(s_r.post + 4'h1);
      end
    end
    s_nxt.tb_match = match;
    s_nxt.pwm_start = start_evt;

    // Sleep without prescaler sync keeps a selected internal oscillator alive.
    keep_osc = sleep_in & ~prescaler_sync_en & on_bit; // see RULE_07
    s_nxt.osc_keep[0] = keep_osc & (s_r.clksel[3:0] == `HLT_CS_LFOSC);
    s_nxt.osc_keep[1] = keep_osc & ((s_r.clksel[3:0] == `HLT_CS_MFOSC_FAST) |
                                    (s_r.clksel[3:0] == `HLT_CS_MFOSC_SLOW));
    s_nxt.osc_keep[2] = keep_osc & (s_r.clksel[3:0] == `HLT_CS_HFOSC);

    // Hardware clear of the enable; a software write in the same cycle wins.
    if (hw_clear_on) begin
      s_nxt.ctrl[`HLT_CTRL_ON] = 1'b0; // see RULE_09
    end

    irq_set = 2'b00;
    irq_set[`HLT_IRQ_MATCH] = s_nxt.post_match;
    irq_set[`HLT_IRQ_START] = start_evt;

    // Register writes land on the edge that ends the pready cycle, one edge after pready rises.
    if (wr_en) begin
      case (paddr)
        `HLT_OFS_CLKSEL: s_nxt.clksel = wbyte & `HLT_SEL_MASK;
        `HLT_OFS_CTRL: s_nxt.ctrl = wbyte;
        `HLT_OFS_LIMIT: s_nxt.limit = wbyte;
        `HLT_OFS_RSTSEL: s_nxt.rstsel = wbyte & `HLT_SEL_MASK;
        `HLT_OFS_COUNT: s_nxt.count = wbyte;
        `HLT_OFS_PERIOD: s_nxt.period = wbyte;
        `HLT_OFS_IRQ_STAT: s_nxt.irq_stat = s_r.irq_stat & ~wbyte[1:0];
        `HLT_OFS_IRQ_MASK: s_nxt.irq_mask = wbyte[1:0];
        default: s_nxt.irq_mask = s_r.irq_mask;
      endcase
    end
    // Event set wins over a write-one clear in the same cycle.
    s_nxt.irq_stat = s_nxt.irq_stat | irq_set;
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);

    case (paddr)
      `HLT_OFS_CLKSEL: rd_val = zext(s_r.clksel);
      `HLT_OFS_CTRL: rd_val = zext(s_r.ctrl);
      `HLT_OFS_LIMIT: rd_val = zext(s_r.limit);
      `HLT_OFS_RSTSEL: rd_val = zext(s_r.rstsel);
      `HLT_OFS_COUNT: rd_val = zext(s_r.count);
      `HLT_OFS_PERIOD: rd_val = zext(s_r.period);
      `HLT_OFS_IRQ_STAT: rd_val = zext({6'h00, s_r.irq_stat});
      `HLT_OFS_IRQ_MASK: rd_val = zext({6'h00, s_r.irq_mask});
      default: rd_val = 32'h00000000;
    endcase

    // One wait state: pready rises on the second access cycle.
    s_nxt.pready = rd_en | (psel & penable & pwrite & ~s_r.pready);
    s_nxt.pslverr = 1'b0;
    if (psel & penable & ~s_r.pready) begin
      s_nxt.pslverr = (paddr[1:0] != 2'b00) || (paddr > `HLT_OFS_IRQ_MASK);
    end
    if (rd_en) begin
      s_nxt.prdata = rd_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r.clksel <= `HLT_RST_REG;
      s_r.ctrl <= `HLT_RST_REG;
      s_r.limit <= `HLT_RST_REG;
      s_r.rstsel <= `HLT_RST_REG;
      s_r.count <= `HLT_RST_REG;
      s_r.period <= `HLT_RST_PERIOD;
      s_r.irq_stat <= 2'b00;
      s_r.irq_mask <= 2'b00;
      s_r.clk_s1 <= 16'h0000;
      s_r.clk_s2 <= 16'h0000;
      s_r.ers_s1 <= 16'h0000;
      s_r.ers_s2 <= 16'h0000;
      s_r.clk_prev <= 1'b0;
      s_r.ers_prev <= 1'b0;
      s_r.presc <= 7'h00;
      s_r.post <= 4'h0;
      s_r.ensync <= 2'b00;
      s_r.state <= hlt_pkg::HLT_ST_IDLE;
      s_r.tb_match <= 1'b0;
      s_r.post_match <= 1'b0;
      s_r.pwm_start <= 1'b0;
      s_r.irq <= 1'b0;
      s_r.osc_keep <= 3'b000;
      s_r.prdata <= 32'h00000000;
      s_r.pready <= 1'b0;
      s_r.pslverr <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign count_o = s_r.count;
  assign tb_match_o = s_r.tb_match;
  assign post_match_o = s_r.post_match;
  assign pwm_start_o = s_r.pwm_start;
  assign osc_keep_o = s_r.osc_keep;
  assign irq_o = s_r.irq;

endmodule
`default_nettype wire

// ---- hlt_timer_sva.sv ----
// Assertion checker for the limit timer, bound to its top module.
// Assumes the constants header and a one-wait-state APB slave.
`include "hlt_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module hlt_timer_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] clk_src_in,
  input wire logic [15:0] ext_reset_src_in,
  input wire logic sleep_in,
  input wire logic [7:0] count_o,
  input wire logic tb_match_o,
  input wire logic post_match_o,
  input wire logic pwm_start_o,
  input wire logic [2:0] osc_keep_o,
  input wire logic irq_o
);
  logic prescaler_sync_en_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow of the prescaler sync bit, taken where a write lands.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prescaler_sync_en_r <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == `HLT_OFS_LIMIT)
      prescaler_sync_en_r <= pwdata[`HLT_LIM_PRESCALER_SYNC_EN];
  end
  a_rdy_pulse: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  a_rdy_access: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready without a held access phase");
  a_err_decode: assert property (pready |-> pslverr == (paddr > 8'h1C || paddr[1:0] != 2'h0))
    else $error("pslverr does not follow the address");
  a_err_rdzero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_rd_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_match_clear: assert property (tb_match_o |-> count_o == 8'h00)
    else $error("count not cleared at period match");
  a_post_match: assert property (post_match_o |-> tb_match_o || $past(tb_match_o))
    else $error("postscaled pulse without a match");
  a_sleep_hold: assert property (sleep_in && $past(sleep_in) && prescaler_sync_en_r |=> $stable(count_o))
    else $error("count moved in sleep with sync set");
endmodule
bind hlt_timer hlt_timer_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .clk_src_in, .ext_reset_src_in, .sleep_in,
  .count_o, .tb_match_o, .post_match_o, .pwm_start_o, .osc_keep_o, .irq_o);
`default_nettype wire

// ---- hlt_far_end.sv ----
// Far-side model: free-running clock sources and external reset sources.
// Assumes the bench sets the reset level; all sources share one level.
`timescale 1ns/1ps
`default_nettype none
module hlt_far_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ers_l,
  output logic [15:0] clk_src,
  output logic [15:0] ers_src
);
  logic [1:0] div_r;
  // Every clock source toggles each fourth cycle, one rising edge per eight.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 2'h0;
      clk_src <= 16'h0000;
    end else begin
      div_r <= div_r + 2'h1;
      if (div_r == 2'h3) clk_src <= ~clk_src;
    end
  end
  assign ers_src = {16{ers_l}};
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench of the limit timer over APB.
// Assumes the far-side model drives the clock and reset sources.
`include "hlt_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr, sleep_in, ers_l;
  logic [7:0] paddr, count_o;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] clk_src_in, ext_reset_src_in;
  logic tb_match_o, post_match_o, pwm_start_o, irq_o, e;
  logic [2:0] osc_keep_o;
  int bad_count = 0, tests_run = 0, pwm_n = 0, n, k;
  time t0;
  always #10 pclk = ~pclk;
  hlt_timer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .clk_src_in, .ext_reset_src_in, .sleep_in, .count_o, .tb_match_o,
    .post_match_o, .pwm_start_o, .osc_keep_o, .irq_o);
  hlt_far_end i_far (.pclk, .presetn, .ers_l, .clk_src(clk_src_in),
    .ers_src(ext_reset_src_in));
  always @(posedge pclk) begin
    if (pwm_start_o === 1'b1) pwm_n++;
  end
  task automatic chk(input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      bad_count++;
      $display("unexpected at %0t: exp %h got %h", $time, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(x, r);
  endtask
  task automatic wm(input bit s, output int c);
    c = 1;
    @(negedge pclk);
    while ((s ? post_match_o : tb_match_o) !== 1'b1 && c < 3000) begin
      c++;
      @(negedge pclk);
    end
    if (c >= 3000) chk(0, c);
  endtask
  task automatic complete_run();
    $display("tests_run %0d bad_count %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, sleep_in, ers_l} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0);
    rd(`HLT_OFS_PERIOD, 32'hFF);
    apb(1'b0, 8'h20, 32'h0);
    chk(1, e);
    chk(0, r);
    wr(`HLT_OFS_CLKSEL, 32'hFF);
    rd(`HLT_OFS_CLKSEL, 32'h0F);
    wr(`HLT_OFS_RSTSEL, 32'hFF);
    rd(`HLT_OFS_RSTSEL, 32'h0F);
    wr(`HLT_OFS_LIMIT, 32'h17);
    rd(`HLT_OFS_LIMIT, 32'h17);
    wr(`HLT_OFS_LIMIT, 32'h0);
    wr(`HLT_OFS_CLKSEL, 32'h1);
    wr(`HLT_OFS_PERIOD, 32'h3);
    for (int p = 0; p < 4; p++) begin
      wr(`HLT_OFS_CTRL, 32'h80 | (p << 4));
      wm(0, n);
      wm(0, n);
      chk(32 << p, n);
    end
    wr(`HLT_OFS_CTRL, 32'h82);
    wr(`HLT_OFS_IRQ_MASK, 32'h1);
    wm(1, n);
    wm(1, n);
    chk(96, n);
    repeat (3) @(negedge pclk);
    chk(1, irq_o);
    wr(`HLT_OFS_CTRL, 32'h0);
    rd(`HLT_OFS_IRQ_STAT, 32'h1);
    wr(`HLT_OFS_IRQ_MASK, 32'h0);
    repeat (2) @(negedge pclk);
    chk(0, irq_o);
    wr(`HLT_OFS_IRQ_STAT, 32'h1);
    wr(`HLT_OFS_IRQ_MASK, 32'h1);
    rd(`HLT_OFS_IRQ_STAT, 32'h0);
    chk(0, irq_o);
    wr(`HLT_OFS_COUNT, 32'h2);
    repeat (60) @(posedge pclk);
    rd(`HLT_OFS_COUNT, 32'h2);
    chk(32'h2, count_o);
    wr(`HLT_OFS_LIMIT, 32'h80);
    sleep_in <= 1'b1;
    wr(`HLT_OFS_CTRL, 32'h80);
    repeat (60) @(posedge pclk);
    rd(`HLT_OFS_COUNT, 32'h2);
    wr(`HLT_OFS_LIMIT, 32'h0);
    wm(0, n);
    wm(0, n);
    chk(32, n);
    wr(`HLT_OFS_CLKSEL, 32'h4);
    repeat (2) @(negedge pclk);
    chk(1, osc_keep_o);
    @(posedge pclk);
    sleep_in <= 1'b0;
    wr(`HLT_OFS_CLKSEL, 32'h1);
    wr(`HLT_OFS_CTRL, 32'h0);
    wr(`HLT_OFS_PERIOD, 32'h14);
    for (int m = 1; m < 4; m++) begin
      ers_l <= (m == 2);
      wr(`HLT_OFS_COUNT, 32'h0);
      wr(`HLT_OFS_LIMIT, 32'h10 | m);
      wr(`HLT_OFS_CTRL, 32'h80);
      k = pwm_n;
      repeat (50) @(posedge pclk);
      rd(`HLT_OFS_COUNT, 32'h0);
      repeat (3) begin
        ers_l <= ~ers_l;
        repeat (40) @(posedge pclk);
      end
      wm(0, n);
      repeat (50) @(posedge pclk);
      rd(`HLT_OFS_COUNT, 32'h0);
      chk(1, pwm_n - k);
      wr(`HLT_OFS_CTRL, 32'h0);
    end
    for (int m = 6; m < 8; m++) begin
      ers_l <= (m == 7);
      wr(`HLT_OFS_LIMIT, 32'h10 | m);
      wr(`HLT_OFS_CTRL, 32'h80);
      k = pwm_n;
      repeat (50) @(posedge pclk);
      rd(`HLT_OFS_COUNT, 32'h0);
      ers_l <= (m == 6);
      wm(0, n);
      rd(`HLT_OFS_CTRL, 32'h0);
      rd(`HLT_OFS_COUNT, 32'h0);
      wr(`HLT_OFS_CTRL, 32'h80);
      wm(0, n);
      chk(2, pwm_n - k);
    end
    // With enable sync the first count step needs three timer clock edges.
    wr(`HLT_OFS_LIMIT, 32'h20);
    wr(`HLT_OFS_COUNT, 32'h0);
    repeat (20) @(posedge pclk);
    wr(`HLT_OFS_CTRL, 32'h80);
    repeat (13) @(posedge pclk);
    rd(`HLT_OFS_COUNT, 32'h0);
    wm(0, n);
    wm(0, n);
    chk(168, n);
    t0 = $time;
    // Falling-edge clocking moves every match by half a source period.
    wr(`HLT_OFS_CTRL, 32'h0);
    wr(`HLT_OFS_LIMIT, 32'h60);
    wr(`HLT_OFS_CTRL, 32'h80);
    wm(0, n);
    chk(32'h50, 32'(($time - t0) % 160));
    complete_run();
  end
  initial begin
    repeat (40000) @(posedge pclk);
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire
